/* design/csda_core.v */
// Decode and cycle sequencing for compare-skip and decimal adjust instructions.
`default_nettype none
`include "csda_regs.vh"

module csda_core
(
	input  wire        sys_clk_in,
	input  wire        reset_in,
	input  wire [15:0] instr_word_in,
	input  wire [7:0]  working_register_in,
	input  wire [3:0]  bank_select_register_in,
	input  wire        ext_set_enable_in,
	input  wire [11:0] index_base_in,
	input  wire [7:0]  data_rd_in,
	input  wire        digit_carry_flag_in,
	input  wire        carry_in,
	output wire [1:0]  phase_out,
	output wire        idle_operation_out,
	output wire [11:0] data_addr_out,
	output wire        data_rd_out,
	output wire        skip_taken_out,
	output wire [7:0]  working_register_out,
	output wire        working_register_we_out,
	output wire        carry_out,
	output wire        carry_we_out
);

	// Skip sequencer states.
	localparam ST_RUN    = 2'h0;
	localparam ST_IDLE_A = 2'h1;
	localparam ST_IDLE_B = 2'h2;

	// Phase counter and skip sequencer; the extra idle flag remembers a two-word victim.
	reg  [1:0]  phase_r;
	reg  [1:0]  phase_nxt;
	reg  [1:0]  state_r;
	reg  [1:0]  state_nxt;
	reg         extra_idle_r;
	reg         extra_idle_nxt;

	// Decoded instruction, held from the decode phase to the end of the cycle.
	reg         is_cmp_r;
	reg         is_cmp_nxt;
	reg         is_adj_r;
	reg         is_adj_nxt;
	reg  [1:0]  cmp_kind_r;
	reg  [1:0]  cmp_kind_nxt;

	// Operand access and the skip verdict of a compare.
	reg  [11:0] addr_r;
	reg  [11:0] addr_nxt;
	reg         rd_r;
	reg         rd_nxt;
	reg         skip_r;
	reg         skip_nxt;
	reg         skip_pulse_r;
	reg         skip_pulse_nxt;

	// Decimal adjust result and the carry flag that it writes back.
	reg  [7:0]  working_register_r;
	reg  [7:0]  working_register_nxt;
	reg         working_register_we_r;
	reg         working_register_we_nxt;
	reg         carry_r;
	reg         carry_nxt;
	reg         adj_carry_r;
	reg         adj_carry_nxt;
	reg  [7:0]  adj_res_r;
	reg  [7:0]  adj_res_nxt;

	// Decode terms and the operand address of the fetched word.
	wire        op_less;
	wire        op_equal;
	wire        op_greater;
	wire        op_adjust;
	wire        bank_bit;
	wire [7:0]  f_addr;
	wire        next_two_word;
	wire [11:0] operand_addr;
	wire        cmp_skip;
	wire [7:0]  adj_result;
	wire        adj_carry;
	wire        running;

	// Opcode recognition on the freshly fetched word.
	assign op_less    = (instr_word_in[15:9] == `CSDA_OP_CMP_LESS);
	assign op_equal   = (instr_word_in[15:9] == `CSDA_OP_CMP_EQUAL);
	assign op_greater = (instr_word_in[15:9] == `CSDA_OP_CMP_GREATER);
	assign op_adjust  = (instr_word_in == `CSDA_OP_DEC_ADJUST);
	assign bank_bit   = instr_word_in[`CSDA_BANK_BIT];
	assign f_addr     = instr_word_in[`CSDA_ADDR_MSB:0];

	// The word fetched after a skipping compare tells whether two idle cycles are due.
	assign next_two_word = (instr_word_in[15:12] == `CSDA_TW_MOVE_HI)
		|| (instr_word_in[15:9] == `CSDA_TW_CALL_HI)
		|| (instr_word_in[15:8] == `CSDA_TW_LFSR_HI)
		|| (instr_word_in[15:8] == `CSDA_TW_GOTO_HI);

	// Operand address: indexed offset, access bank or banked through the select register.
	assign operand_addr = bank_bit
		? {bank_select_register_in, f_addr}
		: (ext_set_enable_in && (f_addr <= `CSDA_INDEX_LIMIT))
			? index_base_in + {4'h0, f_addr}
			: (f_addr >= `CSDA_ACCESS_SPLIT)
				? {`CSDA_ACCESS_HI_BANK, f_addr}
				: {`CSDA_ACCESS_LO_BANK, f_addr};

	// Any state other than running forces an idle operation in place of the fetched word.
	assign running = (state_r == ST_RUN);

	// The compare unit sees the memory byte in Q3; its verdict is kept at the Q3 edge.
	csda_compare u_compare
	(
		.reg_byte_in         (data_rd_in),
		.working_register_in (working_register_in),
		.kind_in             (cmp_kind_r),
		.skip_out            (cmp_skip)
	);

	// The adjust unit works on the working register input, not on data memory.
	csda_decimal_adjust u_adjust
	(
		.working_register_in (working_register_in),
		.digit_carry_flag_in (digit_carry_flag_in),
		.carry_in            (carry_in),
		.result_out          (adj_result),
		.carry_out           (adj_carry)
	);

	// Next-state logic for phases, decode, operand read and skip sequencing.
	always @*
	begin
		phase_nxt      = phase_r + 2'h1;
		state_nxt      = state_r;
		extra_idle_nxt = extra_idle_r;
		is_cmp_nxt     = is_cmp_r;
		is_adj_nxt     = is_adj_r;
		cmp_kind_nxt   = cmp_kind_r;
		addr_nxt       = addr_r;
		rd_nxt         = 1'b0;
		skip_nxt       = skip_r;
		skip_pulse_nxt = 1'b0;
		working_register_nxt    = working_register_r;
		working_register_we_nxt = 1'b0;
		carry_nxt      = carry_r;
		adj_carry_nxt  = adj_carry_r;
		adj_res_nxt    = adj_res_r;
		case (phase_r)
			`CSDA_Q1:
			begin
				if (running)
				begin
					// Decode the fetched word and present the operand address.
					is_cmp_nxt = op_less || op_equal || op_greater;
					is_adj_nxt = op_adjust;
					cmp_kind_nxt = op_greater ? `CSDA_CMP_GREATER
						: op_equal ? `CSDA_CMP_EQUAL : `CSDA_CMP_LESS;
					skip_nxt = 1'b0;
					if (op_less || op_equal || op_greater)
					begin
						addr_nxt = operand_addr;
						rd_nxt   = 1'b1;
					end
				end
				else
				begin
					// Discarded word: no decode; note a two-word instruction.
					is_cmp_nxt = 1'b0;
					is_adj_nxt = 1'b0;
					if (state_r == ST_IDLE_A)
					begin
						extra_idle_nxt = next_two_word;
					end
				end
			end
			`CSDA_Q2:
			begin
				// Operand is being read from data memory; nothing else happens.
			end
			`CSDA_Q3:
			begin
				// Process: compare decides the skip, adjust computes its result.
				// Memory data and the flags are only valid in Q3, so nothing is taken earlier.
				if (is_cmp_r)
				begin
					skip_nxt = cmp_skip;
				end
				if (is_adj_r)
				begin
					adj_res_nxt   = adj_result;
					adj_carry_nxt = adj_carry;
				end
			end
			`CSDA_Q4:
			begin
				// Compares write nothing; only the adjust writes back.
				if (is_adj_r)
				begin
					working_register_nxt    = adj_res_r;
					working_register_we_nxt = 1'b1;
					carry_nxt   = adj_carry_r;
				end
				case (state_r)
					ST_RUN:
					begin
						if (is_cmp_r && skip_r)
						begin
							state_nxt      = ST_IDLE_A;
							skip_pulse_nxt = 1'b1;
						end
						// No skip: the compare ends after this one cycle.
					end
					ST_IDLE_A:
					begin
						// The two-word test was made in this cycle's Q1.
						state_nxt = extra_idle_r ? ST_IDLE_B : ST_RUN;
					end
					ST_IDLE_B:
					begin
						// The second word of the skipped instruction passes here unread.
						state_nxt = ST_RUN;
					end
					default:
					begin
						// The unused state code recovers to running.
						state_nxt = ST_RUN;
					end
				endcase
			end
			default:
			begin
				phase_nxt = `CSDA_Q1;
			end
		endcase
	end

	// State registers; the reset puts the core at Q1 running.
	// The reset is synchronous, so the phase counter restarts cleanly on an edge.
	always @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			phase_r      <= `CSDA_Q1;
			state_r      <= ST_RUN;
			extra_idle_r <= 1'b0;
			is_cmp_r     <= 1'b0;
			is_adj_r     <= 1'b0;
			cmp_kind_r   <= `CSDA_CMP_LESS;
			addr_r       <= `CSDA_RST_ADDR;
			rd_r         <= 1'b0;
			skip_r       <= 1'b0;
			skip_pulse_r <= 1'b0;
			working_register_r    <= `CSDA_RST_BYTE;
			working_register_we_r <= 1'b0;
			carry_r      <= 1'b0;
			adj_carry_r  <= 1'b0;
			adj_res_r    <= `CSDA_RST_BYTE;
		end
		else
		begin
			phase_r      <= phase_nxt;
			state_r      <= state_nxt;
			extra_idle_r <= extra_idle_nxt;
			is_cmp_r     <= is_cmp_nxt;
			is_adj_r     <= is_adj_nxt;
			cmp_kind_r   <= cmp_kind_nxt;
			addr_r       <= addr_nxt;
			rd_r         <= rd_nxt;
			skip_r       <= skip_nxt;
			skip_pulse_r <= skip_pulse_nxt;
			working_register_r    <= working_register_nxt;
			working_register_we_r <= working_register_we_nxt;
			carry_r      <= carry_nxt;
			adj_carry_r  <= adj_carry_nxt;
			adj_res_r    <= adj_res_nxt;
		end
	end

	// Outputs; the idle flag tells the core to execute an idle operation.
	assign phase_out               = phase_r;
	assign idle_operation_out      = !running;
	assign data_addr_out           = addr_r;
	assign data_rd_out             = rd_r;
	assign skip_taken_out          = skip_pulse_r;
	assign working_register_out    = working_register_r;
	assign working_register_we_out = working_register_we_r;
	// Carry is written together with the working register on every adjust.
	assign carry_out               = carry_r;
	assign carry_we_out            = working_register_we_r;

endmodule // csda_core
`default_nettype wire

/* common/csda_regs.vh */
// Constants for the compare-skip and decimal adjust execution block.
`ifndef CSDA_REGS_VH
`define CSDA_REGS_VH

// Opcode patterns on instruction bits 15:9 (decimal adjust on the whole word), bit 8 being the bank-access select.
`define CSDA_OP_CMP_LESS     7'h30
`define CSDA_OP_CMP_EQUAL    7'h31
`define CSDA_OP_CMP_GREATER  7'h32
`define CSDA_OP_DEC_ADJUST   16'h0007
`define CSDA_BANK_BIT        8
`define CSDA_ADDR_MSB        7

// Compare kinds passed to the compare unit.
`define CSDA_CMP_LESS        2'h0
`define CSDA_CMP_EQUAL       2'h1
`define CSDA_CMP_GREATER     2'h2

// Two-word instruction first-word patterns.
`define CSDA_TW_MOVE_HI      4'hC
`define CSDA_TW_CALL_HI      7'h76
`define CSDA_TW_LFSR_HI      8'hEE
`define CSDA_TW_GOTO_HI      8'hEF

// Data memory addressing.
`define CSDA_ACCESS_SPLIT    8'h80
`define CSDA_ACCESS_HI_BANK  4'hF
`define CSDA_ACCESS_LO_BANK  4'h0
`define CSDA_INDEX_LIMIT     8'h5F

// Packed BCD correction.
`define CSDA_BCD_LIMIT       5'h09
`define CSDA_BCD_CORR        5'h06

// Internal phases of one instruction cycle.
`define CSDA_Q1              2'h0
`define CSDA_Q2              2'h1
`define CSDA_Q3              2'h2
`define CSDA_Q4              2'h3

// Reset values.
`define CSDA_RST_BYTE        8'h00
`define CSDA_RST_ADDR        12'h000

`endif

/* design/csda_compare.v */
// Unsigned compare unit that decides whether a compare instruction skips.
`default_nettype none
`include "csda_regs.vh"

module csda_compare
(
	input  wire [7:0] reg_byte_in,
	input  wire [7:0] working_register_in,
	input  wire [1:0] kind_in,
	output reg        skip_out
);

	wire [8:0] diff;
	wire       borrow;
	wire       zero;

	// The register byte minus the working register; only the flags are kept.
	assign diff   = {1'b0, reg_byte_in} - {1'b0, working_register_in};
	assign borrow = diff[8];
	assign zero   = (diff[7:0] == 8'h00);

	// Pick the relation that the instruction asks for.
	always @*
	begin
		case (kind_in)
			`CSDA_CMP_EQUAL:   skip_out = zero;
			`CSDA_CMP_GREATER: skip_out = !borrow && !zero;
			`CSDA_CMP_LESS:    skip_out = borrow;
			default:           skip_out = 1'b0;
		endcase
	end

endmodule // csda_compare
`default_nettype wire

/* design/csda_decimal_adjust.v */
// Packed BCD correction of the working register after an addition.
`default_nettype none
`include "csda_regs.vh"

module csda_decimal_adjust
(
	input  wire [7:0] working_register_in,
	input  wire       digit_carry_flag_in,
	input  wire       carry_in,
	output wire [7:0] result_out,
	output wire       carry_out
);

	wire       adj_lo;
	wire [4:0] lo_sum;
	wire [4:0] hi_pre;
	wire       adj_hi;
	wire [4:0] hi_sum;

	// Low digit gets six added when above nine or when a digit carry occurred.
	assign adj_lo = ({1'b0, working_register_in[3:0]} > `CSDA_BCD_LIMIT)
		|| digit_carry_flag_in;
	assign lo_sum = {1'b0, working_register_in[3:0]} + (adj_lo ? `CSDA_BCD_CORR : 5'h00);

	// High digit takes the carry out of the low correction, then its own correction.
	assign hi_pre = {1'b0, working_register_in[7:4]} + {4'h0, lo_sum[4]};
	assign adj_hi = (hi_pre > `CSDA_BCD_LIMIT) || carry_in;
	assign hi_sum = hi_pre + (adj_hi ? `CSDA_BCD_CORR : 5'h00);

	// A high-digit correction means the decimal result passed 99.
	assign result_out = {hi_sum[3:0], lo_sum[3:0]};
	assign carry_out  = adj_hi;

endmodule // csda_decimal_adjust
`default_nettype wire

/* verif/csda_checker.sv */
// Concurrent checks on the ports of the compare-skip and decimal adjust block.
`default_nettype none
module csda_checker
(
	input wire logic        sys_clk_in,
	input wire logic        reset_in,
	input wire logic [15:0] instr_word_in,
	input wire logic [7:0]  working_register_in,
	input wire logic [3:0]  bank_select_register_in,
	input wire logic        ext_set_enable_in,
	input wire logic [11:0] index_base_in,
	input wire logic [7:0]  data_rd_in,
	input wire logic [1:0]  phase_out,
	input wire logic        idle_operation_out,
	input wire logic [11:0] data_addr_out,
	input wire logic        data_rd_out,
	input wire logic        skip_taken_out,
	input wire logic        working_register_we_out,
	input wire logic        carry_we_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        dec;
	logic        cmp;
	logic        hit;
	logic        tw;
	logic        idl;
	logic        we;
	logic [7:0]  f;
	logic [1:0]  kind_r;
	logic [11:0] addr_r;

	// Decode slot, compare opcode, skip relation and two-word first word.
	assign dec = phase_out == 2'h0 && !idle_operation_out;
	assign cmp = instr_word_in[15:11] == 5'h0C && instr_word_in[10:9] != 2'h3;
	assign f = instr_word_in[7:0];
	assign hit = kind_r == 2'h1 ? data_rd_in == working_register_in :
		kind_r == 2'h2 ? data_rd_in > working_register_in : data_rd_in < working_register_in;
	assign tw = instr_word_in[15:12] == 4'hC || instr_word_in[15:10] == 6'h3B;
	assign idl = idle_operation_out;
	assign we = working_register_we_out;

	// Compare kind and expected operand address are latched at decode.
	always @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			kind_r <= 2'h0;
			addr_r <= 12'h000;
		end
		else if (dec && cmp)
		begin
			kind_r <= instr_word_in[10:9];
			addr_r <= instr_word_in[8] ? {bank_select_register_in, f} :
				ext_set_enable_in && f <= 8'h5F ? index_base_in + {4'h0, f} :
				{(f[7] ? 4'hF : 4'h0), f};
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	sequence cmp_dec;
		dec && cmp;
	endsequence
	sequence q3_hit;
		data_rd_out ##1 hit;
	endsequence
	sequence q3_miss;
		data_rd_out ##1 !hit;
	endsequence

	rd_decode_a: assert property (cmp_dec |=> data_rd_out)
		else $error("compare not decoded");
	rd_pulse_a: assert property (data_rd_out |-> phase_out == 2'h1 ##1 !data_rd_out)
		else $error("read strobe misplaced");
	oper_addr_a: assert property (data_rd_out |-> data_addr_out == addr_r)
		else $error("operand address wrong");
	skip_hit_a: assert property (q3_hit |-> ##2 skip_taken_out && idl)
		else $error("skip missing");
	skip_miss_a: assert property (q3_miss |-> ##2 !skip_taken_out && !idl)
		else $error("spurious skip");
	one_idle_a: assert property (skip_taken_out && !tw |-> idl[*4] ##1 !idl)
		else $error("single idle length");
	two_idle_a: assert property (skip_taken_out && tw |-> idl[*8] ##1 !idl)
		else $error("double idle length");
	cmp_nowr_a: assert property (cmp_dec |=> !we[*4])
		else $error("compare wrote");
	adj_wr_a: assert property (dec && instr_word_in == 16'h0007 |-> ##4 we && carry_we_out)
		else $error("adjust write missing");
endmodule // csda_checker
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the compare-skip and decimal adjust block.
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Row: word, working reg, memory, {ext,digit carry,carry,bank}, next word,
	// {idles,2'b0,addr or carry+result}.
	typedef struct packed {
		logic [15:0] i;
		logic [7:0]  w;
		logic [7:0]  d;
		logic [6:0]  c;
		logic [15:0] f;
		logic [15:0] e;
	} csda_row_t;
	logic        sys_clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [15:0] instr_word_in = 16'h0000;
	logic [7:0]  working_register_in = 8'h00;
	logic [7:0]  data_rd_in = 8'h00;
	logic [3:0]  bank_select_register_in = 4'h0;
	logic        ext_set_enable_in = 1'b0;
	logic [11:0] index_base_in = 12'h123;
	logic        digit_carry_flag_in = 1'b0;
	logic        carry_in = 1'b0;
	wire  [1:0]  phase_out;
	wire         idle_operation_out;
	wire  [11:0] data_addr_out;
	wire         data_rd_out;
	wire         skip_taken_out;
	wire  [7:0]  working_register_out;
	wire         working_register_we_out;
	wire         carry_out;
	wire         carry_we_out;
	int          n_errors = 0;
	int          n_checks = 0;
	int          cycles = 0;
	csda_row_t   rows[14] = '{
		'{16'h6342, 8'h55, 8'h55, 7'h03, 16'hC123, 16'h8342},
		'{16'h6290, 8'h55, 8'h54, 7'h03, 16'h0000, 16'h0F90},
		'{16'h6410, 8'h80, 8'h81, 7'h03, 16'h6200, 16'h4010},
		'{16'h6510, 8'h80, 8'h80, 7'h0A, 16'h0000, 16'h0A10},
		'{16'h6020, 8'h01, 8'h00, 7'h4A, 16'hEC00, 16'h8143},
		'{16'h605F, 8'hFF, 8'hFF, 7'h4A, 16'h0000, 16'h0182},
		'{16'h6060, 8'h00, 8'hFF, 7'h4A, 16'h0000, 16'h0060},
		'{16'h6480, 8'h00, 8'hFF, 7'h0A, 16'hEE00, 16'h8F80},
		'{16'h62FF, 8'h00, 8'h00, 7'h0A, 16'hEF00, 16'h8FFF},
		'{16'h6105, 8'h02, 8'h01, 7'h4F, 16'h1234, 16'h4F05},
		'{16'h0007, 8'h9A, 8'h00, 7'h00, 16'h0000, 16'h0100},
		'{16'h0007, 8'h08, 8'h00, 7'h20, 16'h0000, 16'h000E},
		'{16'h0007, 8'h30, 8'h00, 7'h10, 16'h0000, 16'h0190},
		'{16'h0007, 8'hCE, 8'h00, 7'h00, 16'h0000, 16'h0134}};

	csda_core i_csda_core (.*);

	// Clock of 100 ns period.
	always #50 sys_clk_in = ~sys_clk_in;

	// Cycle ceiling that cuts a hang short.
	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 400)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Runs one row from its decode slot to the next free decode slot.
	task automatic run(input csda_row_t r);
		instr_word_in = r.i;
		working_register_in = r.w;
		data_rd_in = r.d;
		{ext_set_enable_in, digit_carry_flag_in, carry_in, bank_select_register_in} = r.c;
		@(posedge sys_clk_in);
		#10;
		instr_word_in = r.f;
		if (r.i != 16'h0007)
		begin
			`CHK("read strobe", 1'b1, data_rd_out)
			`CHK("address", r.e[11:0], data_addr_out)
		end
		repeat (3) @(posedge sys_clk_in);
		#10;
		`CHK("skip", r.e[15:14] != 2'h0, skip_taken_out)
		`CHK("write", r.i == 16'h0007, working_register_we_out)
		`CHK("carry write", r.i == 16'h0007, carry_we_out)
		if (r.i == 16'h0007)
		begin
			`CHK("result", r.e[8:0], {carry_out, working_register_out})
		end
		for (int k = 0; k < r.e[15:14]; k++)
		begin
			`CHK("idle", 1'b1, idle_operation_out)
			repeat (4) @(posedge sys_clk_in);
			#10;
		end
		`CHK("idle end", 1'b0, idle_operation_out)
	endtask

	// Reset, the table of rows, then a reset in the middle of a skip.
	initial
	begin
		repeat (4) @(posedge sys_clk_in);
		#10;
		reset_in = 1'b0;
		foreach (rows[j])
			run(rows[j]);
		instr_word_in = 16'h6342;
		working_register_in = 8'h00;
		repeat (5) @(posedge sys_clk_in);
		#10;
		reset_in = 1'b1;
		@(posedge sys_clk_in);
		#10;
		`CHK("reset idle", 1'b0, idle_operation_out)
		`CHK("reset phase", 2'h0, phase_out)
		reset_in = 1'b0;
		run(rows[0]);
		report_and_stop();
	end
endmodule // tb

bind csda_core csda_checker i_csda_checker (.*);
`default_nettype wire
